/* File: core/pss_sram_port.v */
`include "pss_regs.vh"

module pss_sram_port (
  input  wire                     clk_i,                  // Sampling clock
  input  wire                     resetn_i,               // Async reset, active low
  input  wire                     clock_enable_n_i,       // Low lets edges through
  input  wire [`PSS_ADDR_W-1:0]   addr_in_i,              // Word address
  input  wire                     load_or_step_i,         // Low load, high step
  input  wire                     select_low_primary_n_i, // Chip select, active low
  input  wire                     select_high_expand_i,   // Chip select, active high
  input  wire                     select_low_expand_n_i,  // Chip select, active low
  input  wire                     write_request_n_i,      // Low write, high read
  input  wire [`PSS_LANES-1:0]    lane_write_n_i,         // Per-lane write enables
  input  wire                     out_enable_n_i,         // Async output enable
  input  wire                     burst_order_sel_i,      // Static burst order
  input  wire                     sleep_request_i,        // Async sleep, active high
  input  wire [`PSS_DATA_W-1:0]   data_lanes_i,           // Data pins, in
  output wire [`PSS_DATA_W-1:0]   data_lanes_o,           // Data pins, out
  output wire                     data_lanes_oe_o,        // High while driving pins
  output wire                     low_power_o             // Low-power state
);

  reg  [`PSS_DATA_W-1:0] mem [0:`PSS_DEPTH-1];

  // Sleep synchroniser, runs on the free clock to spot release
  reg                    sleep_sync_1;
  reg                    sleep_sync_2;
  reg                    sleep_sync_3;
  reg                    low_power;

  // Burst state
  reg                    burst_active;
  reg                    burst_write;
  reg  [`PSS_BLOCK_W-1:0] burst_base;
  reg  [`PSS_BURST_W-1:0] burst_start;
  reg  [`PSS_BURST_W-1:0] burst_count;

  // Input register stage
  reg                    cap_valid;
  reg                    cap_write;
  reg  [`PSS_ADDR_W-1:0] cap_addr;
  reg  [`PSS_DATA_W-1:0] cap_data;
  reg  [`PSS_LANES-1:0]  cap_lanes_n;

  // Output register stage
  reg  [`PSS_DATA_W-1:0] out_data;
  reg                    out_valid;

  wire                   edge_en;
  wire                   selected;
  wire                   cmd_load;
  wire                   cmd_step;
  wire                   sleep_seen;
  wire                   sleep_gone;
  wire [`PSS_BURST_W-1:0] next_count;
  wire [`PSS_BURST_W-1:0] step_word;

  reg                    next_valid;
  reg                    next_write;
  reg  [`PSS_ADDR_W-1:0] next_addr;

  integer                lane;

  // Internal clock gate: stopped by clock enable or the raw sleep pin
  assign edge_en = ~clock_enable_n_i & ~sleep_request_i;

  assign selected = ~select_low_primary_n_i
                  & select_high_expand_i
                  & ~select_low_expand_n_i;

  assign cmd_load = ~load_or_step_i & selected;
  assign cmd_step = load_or_step_i & burst_active & ~low_power;

  assign sleep_seen = sleep_sync_2 & sleep_sync_3;
  assign sleep_gone = ~sleep_sync_2 & ~sleep_sync_3;

  assign next_count = burst_count + `PSS_BURST_ONE;

  pss_burst_seq u_seq (
    .start_i (burst_start),
    .count_i (next_count),
    .order_i (burst_order_sel_i),
    .word_o  (step_word)
  );

  // Access presented to the input register this edge
  always @* begin
    next_valid = cmd_load | cmd_step;
    next_write = burst_write;
    next_addr  = {burst_base, step_word};
    if (cmd_load) begin
      next_write = ~write_request_n_i;
      next_addr  = addr_in_i;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_sync_1 <= `PSS_RST_SYNC;
      sleep_sync_2 <= `PSS_RST_SYNC;
      sleep_sync_3 <= `PSS_RST_SYNC;
    end else begin
      sleep_sync_1 <= sleep_request_i;
      sleep_sync_2 <= sleep_sync_1;
      sleep_sync_3 <= sleep_sync_2;
    end
  end

  // Low power holds after release until a read or write arrives
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_power <= `PSS_RST_LP;
    end else if (sleep_seen) begin
      low_power <= 1'b1;
    end else if (low_power && sleep_gone && edge_en && cmd_load) begin
      low_power <= 1'b0;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      burst_active <= `PSS_RST_VALID;
      burst_write  <= `PSS_RST_VALID;
      burst_base   <= `PSS_RST_BASE;
      burst_start  <= `PSS_BURST_ZERO;
      burst_count  <= `PSS_BURST_ZERO;
    end else if (edge_en) begin
      if (!load_or_step_i) begin
        burst_active <= selected;
        if (selected) begin
          burst_write <= ~write_request_n_i;
          burst_base  <= addr_in_i[`PSS_ADDR_W-1:`PSS_BURST_W];
          burst_start <= addr_in_i[`PSS_BURST_W-1:0];
          burst_count <= `PSS_BURST_ZERO;
        end
      end else if (cmd_step) begin
        burst_count <= next_count;
      end
    end
  end

  // Input registers: address, data and controls on the rising edge
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_valid   <= `PSS_RST_VALID;
      cap_write   <= `PSS_RST_VALID;
      cap_addr    <= `PSS_RST_ADDR;
      cap_data    <= `PSS_RST_DATA;
      cap_lanes_n <= `PSS_RST_LANES_N;
    end else if (edge_en) begin
      cap_valid   <= next_valid;
      cap_write   <= next_write;
      cap_addr    <= next_addr;
      cap_data    <= data_lanes_i;
      cap_lanes_n <= lane_write_n_i;
    end
  end

  // Array write, lane by lane; the array has no reset so sleep keeps it
  always @(posedge clk_i) begin
    if (edge_en && cap_valid && cap_write) begin
      for (lane = 0; lane < `PSS_LANES; lane = lane + 1) begin
        if (!cap_lanes_n[lane]) begin
          mem[cap_addr][lane*`PSS_LANE_W +: `PSS_LANE_W] <=
            cap_data[lane*`PSS_LANE_W +: `PSS_LANE_W];
        end
      end
    end
  end

  // Output register, loaded one edge after the read is captured
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_data  <= `PSS_RST_DATA;
      out_valid <= `PSS_RST_VALID;
    end else if (edge_en) begin
      out_valid <= cap_valid & ~cap_write;
      if (cap_valid && !cap_write) begin
        out_data <= mem[cap_addr];
      end
    end
  end

  assign data_lanes_o    = out_data;
  assign data_lanes_oe_o = ~out_enable_n_i & out_valid & ~low_power
                         & ~sleep_request_i;
  assign low_power_o     = low_power;

endmodule

/* File: core/pss_regs.vh */
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

// Array organisation
`define PSS_ADDR_W      18
`define PSS_BLOCK_W     16
`define PSS_DEPTH       262144
`define PSS_DATA_W      36
`define PSS_LANES       4
`define PSS_LANE_W      9

// Burst counter
`define PSS_BURST_W     2
`define PSS_BURST_ONE   2'h1
`define PSS_BURST_ZERO  2'h0

// Burst order select levels
`define PSS_ORDER_LIN   1'b0
`define PSS_ORDER_INT   1'b1

// Reset values of control state
`define PSS_RST_LP      1'b0
`define PSS_RST_VALID   1'b0
`define PSS_RST_SYNC    1'b0
`define PSS_RST_ADDR    18'h00000
`define PSS_RST_BASE    16'h0000
`define PSS_RST_DATA    36'h000000000
`define PSS_RST_LANES_N 4'hF

`endif

/* File: core/pss_burst_seq.v */
`include "pss_regs.vh"

// Next word within the four-word block, linear or interleaved
module pss_burst_seq (
  input  wire [`PSS_BURST_W-1:0] start_i,  // Low address bits at load
  input  wire [`PSS_BURST_W-1:0] count_i,  // Words stepped since load
  input  wire                    order_i,  // High selects interleaved
  output wire [`PSS_BURST_W-1:0] word_o    // Word offset to access
);

  function [`PSS_BURST_W-1:0] burst_word;
    input [`PSS_BURST_W-1:0] start;
    input [`PSS_BURST_W-1:0] count;
    input                    order;
    begin
      if (order == `PSS_ORDER_INT) begin
        burst_word = start ^ count;
      end else begin
        burst_word = start + count;
      end
    end
  endfunction

  assign word_o = burst_word(start_i, count_i, order_i);

endmodule

/* File: verification/pss_ctrl_model.sv */
`include "pss_regs.vh"

module pss_ctrl_model (
  input  wire logic                   clk_i,
  input  wire logic                   drive_i,
  input  wire logic [`PSS_DATA_W-1:0] wdata_i,
  input  wire logic                   dev_oe_i,
  input  wire logic [`PSS_DATA_W-1:0] dev_data_i,
  output logic      [`PSS_DATA_W-1:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`PSS_DATA_W-1:0] last = '0;
  // Released bus shows the inverse of its last level
  assign bus_o = drive_i ? wdata_i : dev_oe_i ? dev_data_i : ~last;
  always @(posedge clk_i) last <= bus_o;
endmodule

/* File: verification/pss_sram_port_monitor.sv */
`include "pss_regs.vh"

module pss_sram_port_monitor (
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire logic                   clock_enable_n_i,
  input wire logic                   load_or_step_i,
  input wire logic                   select_low_primary_n_i,
  input wire logic                   select_high_expand_i,
  input wire logic                   select_low_expand_n_i,
  input wire logic                   write_request_n_i,
  input wire logic                   out_enable_n_i,
  input wire logic                   sleep_request_i,
  input wire logic [`PSS_DATA_W-1:0] data_lanes_o,
  input wire logic                   data_lanes_oe_o,
  input wire logic                   low_power_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  wire en   = !clock_enable_n_i && !sleep_request_i;
  wire load = en && !load_or_step_i;
  wire sel  = !select_low_primary_n_i && select_high_expand_i && !select_low_expand_n_i;
  sequence s_read;
    load && sel && write_request_n_i && !low_power_o;
  endsequence
  sequence s_open;
    en ##1 !out_enable_n_i && !sleep_request_i && !low_power_o;
  endsequence
  a_read_drive: assert property (s_read ##1 s_open |-> data_lanes_oe_o)
    else $error("read data not driven");
  a_write_quiet: assert property (load && !write_request_n_i ##1 en |=> !data_lanes_oe_o)
    else $error("pins driven after write");
  a_sel1_off: assert property (load && select_low_primary_n_i ##1 en |=> !data_lanes_oe_o)
    else $error("first select ignored");
  a_sel2_off: assert property (load && !select_high_expand_i ##1 en |=> !data_lanes_oe_o)
    else $error("second select ignored");
  a_sel3_off: assert property (load && select_low_expand_n_i ##1 en |=> !data_lanes_oe_o)
    else $error("third select ignored");
  a_oe_gate: assert property (out_enable_n_i || sleep_request_i |-> !data_lanes_oe_o)
    else $error("pins driven while disabled");
  a_edge_frozen: assert property (!en |=> $stable(data_lanes_o))
    else $error("output moved on a gated edge");
  a_wake_load: assert property ($fell(low_power_o) |-> $past(load) && $past(sel))
    else $error("woke without a command");
endmodule

bind pss_sram_port pss_sram_port_monitor u_pss_sram_port_monitor (
  .clk_i, .resetn_i, .clock_enable_n_i, .load_or_step_i, .select_low_primary_n_i,
  .select_high_expand_i, .select_low_expand_n_i, .write_request_n_i, .out_enable_n_i,
  .sleep_request_i, .data_lanes_o, .data_lanes_oe_o, .low_power_o);

/* File: verification/tb_pss_sram_port.sv */
`include "pss_regs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp=%h got=%h", n, e, g); end end

module tb_pss_sram_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_i = 0, resetn_i = 0, clock_enable_n_i = 0, load_or_step_i = 0;
  logic                   select_low_primary_n_i = 1, select_high_expand_i = 0, k = 0, z = 0;
  logic                   select_low_expand_n_i = 1, write_request_n_i = 1, out_enable_n_i = 0;
  logic                   burst_order_sel_i = 0, sleep_request_i = 0, drv = 0;
  logic                   data_lanes_oe_o, low_power_o;
  logic [`PSS_ADDR_W-1:0] addr_in_i = '0;
  logic [`PSS_LANES-1:0]  lane_write_n_i = '0, ln = '0;
  logic [`PSS_DATA_W-1:0] data_lanes_i, data_lanes_o, wdat = '0;
  logic [`PSS_DATA_W:0]   e1 = '0, e2 = '0;
  int                     fail_count = 0, comparisons = 0, cyc = 0;
  localparam logic [2:0]  ACT = 3'h2, OFF = 3'h6;

  pss_sram_port u_pss_sram_port (.clk_i, .resetn_i, .clock_enable_n_i, .addr_in_i,
    .load_or_step_i, .select_low_primary_n_i, .select_high_expand_i, .select_low_expand_n_i,
    .write_request_n_i, .lane_write_n_i, .out_enable_n_i, .burst_order_sel_i,
    .sleep_request_i, .data_lanes_i, .data_lanes_o, .data_lanes_oe_o, .low_power_o);
  pss_ctrl_model u_pss_ctrl_model (.clk_i, .drive_i(drv), .wdata_i(wdat),
    .dev_oe_i(data_lanes_oe_o), .dev_data_i(data_lanes_o), .bus_o(data_lanes_i));

  initial forever #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One command per edge; checks the read launched two edges earlier
  task automatic op(input logic l, w, input logic [2:0] s, input logic [17:0] a,
                    input logic [35:0] d, input logic [36:0] e);
    @(posedge clk_i);
    load_or_step_i <= l;
    write_request_n_i <= w;
    {select_low_primary_n_i, select_high_expand_i, select_low_expand_n_i} <= s;
    addr_in_i <= a;
    wdat <= d;
    drv <= !w;
    lane_write_n_i <= ln;
    clock_enable_n_i <= k;
    sleep_request_i <= z;
    #1;
    if (e2[36]) `CHK("read", {1'h1, e2[35:0]}, {data_lanes_oe_o, data_lanes_o})
    e2 = e1;
    e1 = e;
  endtask

  task automatic fl;
    repeat (2) op(0, 1, OFF, '0, '0, '0);
  endtask

  function automatic logic [35:0] dat(input logic o, input logic [1:0] j);
    return {32'h5A5A5A5A, o, 1'h0, j};
  endfunction

  function automatic logic [1:0] wrd(input logic o, input logic [1:0] s, c);
    return o ? s ^ c : s + c;
  endfunction

  task automatic t_lanes;
    op(0, 0, ACT, 18'h00200, 36'h123456789, '0);
    ln = 4'h5;
    op(0, 0, ACT, 18'h00200, 36'hFEDCBA987, '0);
    ln = 4'h0;
    op(0, 1, ACT, 18'h00200, '0, {1'h1, 36'hFEB47A989});
    fl();
  endtask

  task automatic t_burst(input logic o);
    logic [17:0] b;
    b = 18'h00100 | {15'h0, o, 2'h0};
    @(posedge clk_i) burst_order_sel_i <= o;
    for (int i = 0; i < 4; i++)
      op(i != 0, 0, ACT, i ? ~b : {b[17:2], 2'h1}, dat(o, wrd(o, 2'h1, i[1:0])), '0);
    for (int i = 0; i < 8; i++)
      op(i != 0, 1, ACT, i ? ~b : {b[17:2], 2'h3}, '0,
         {1'h1, dat(o, wrd(o, 2'h3, i[1:0]))});
    fl();
  endtask

  task automatic t_select;
    op(0, 0, ACT, 18'h00300, '0, '0);
    for (int i = 0; i < 3; i++)
      op(0, 0, ACT ^ (3'h1 << i), 18'h00300, '1, '0);
    k = 1;
    op(0, 0, ACT, 18'h00300, '1, '0);
    k = 0;
    op(0, 1, ACT, 18'h00300, '0, {1'h1, 36'h0});
    fl();
  endtask

  task automatic t_sleep;
    op(0, 0, ACT, 18'h00400, 36'h0C3C3C3C3, '0);
    z = 1;
    op(0, 0, ACT, 18'h00400, '0, '0);
    repeat (5) op(0, 1, OFF, '0, '0, '0);
    `CHK("low_power", 1'h1, low_power_o)
    z = 0;
    repeat (4) op(0, 1, OFF, '0, '0, '0);
    `CHK("low_power", 1'h1, low_power_o)
    op(0, 1, ACT, 18'h00400, '0, {1'h1, 36'h0C3C3C3C3});
    fl();
    `CHK("low_power", 1'h0, low_power_o)
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1;
    t_lanes();
    t_burst(0);
    t_burst(1);
    t_select();
    t_sleep();
    test_done();
  end
endmodule
